//--- design/cmt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmt_consts.svh"
module cmt_ctrl
	import cmt_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_cp_valid,
	input wire logic i_cp_write,
	input wire logic [3:0] i_cp_crn,
	input wire logic [3:0] i_cp_crm,
	input wire logic [2:0] i_cp_op2,
	input wire logic [31:0] i_cp_wdata,
	output logic o_cp_ready,
	output logic [31:0] o_cp_rdata,
	input wire logic i_abort_take,
	input wire logic i_abort_data,
	input wire logic i_abort_ext,
	input wire logic i_abort_dbg,
	input wire logic [3:0] i_abort_domain,
	input wire logic [3:0] i_abort_type,
	input wire logic [31:0] i_abort_mva,
	input wire logic [31:0] i_ifetch_va,
	input wire logic [31:0] i_data_va,
	output logic [31:0] o_ifetch_mva,
	output logic [31:0] o_data_mva,
	input wire logic i_mem_idle,
	input wire logic i_dc_resident,
	output logic [31:0] o_probe_mva,
	output cmt_maint_type o_maint,
	input wire logic i_clean_done,
	input wire logic i_clean_parity,
	output logic o_parity_fault,
	output logic o_dc_lock_mode
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [31:0] cmt_remap(input logic [31:0] va,
		input logic [6:0] process_remap_id);
		logic top_zero;
		top_zero = (va[`CMT_PID_HI:`CMT_PID_LO] == 7'h00);
		cmt_remap = top_zero ? (va | {process_remap_id, 25'h0000000}) : va;
	endfunction

	function automatic cmt_op_type cmt_decode(input logic [3:0] crn,
		input logic [3:0] minor_register_field, input logic [2:0] op2);
		cmt_op_type op;
		op = CMT_OP_NONE;
		case (crn)
			`CMT_CRN_CACHE: begin
				if (op2 == `CMT_OP2_0) begin
					if (minor_register_field == `CMT_CRM_7) op = CMT_OP_INV_ID_BTB;
					if (minor_register_field == `CMT_CRM_5) op = CMT_OP_INV_I_BTB;
					if (minor_register_field == `CMT_CRM_6) op = CMT_OP_INV_D;
				end
				if (op2 == `CMT_OP2_1) begin
					if (minor_register_field == `CMT_CRM_5) op = CMT_OP_INV_I_LINE;
					if (minor_register_field == `CMT_CRM_6) op = CMT_OP_INV_D_LINE;
					if (minor_register_field == `CMT_CRM_A) op = CMT_OP_CLEAN_D_LINE;
				end
				if (op2 == `CMT_OP2_4 && minor_register_field == `CMT_CRM_A)
					op = CMT_OP_DRAIN;
				if (op2 == `CMT_OP2_6 && minor_register_field == `CMT_CRM_5)
					op = CMT_OP_INV_BTB;
				if (op2 == `CMT_OP2_5 && minor_register_field == `CMT_CRM_2)
					op = CMT_OP_ALLOC_LINE;
			end
			`CMT_CRN_TLB: begin
				if (op2 == `CMT_OP2_0) begin
					if (minor_register_field == `CMT_CRM_7) op = CMT_OP_TLB_INV_ALL;
					if (minor_register_field == `CMT_CRM_5) op = CMT_OP_TLB_INV_I;
					if (minor_register_field == `CMT_CRM_6) op = CMT_OP_TLB_INV_D;
				end
				if (op2 == `CMT_OP2_1) begin
					if (minor_register_field == `CMT_CRM_5) op = CMT_OP_TLB_INV_I_ENT;
					if (minor_register_field == `CMT_CRM_6) op = CMT_OP_TLB_INV_D_ENT;
				end
			end
			`CMT_CRN_CLOCK: begin
				if (minor_register_field == `CMT_CRM_1 && op2 == `CMT_OP2_0)
					op = CMT_OP_ILOCK_LINE;
				if (minor_register_field == `CMT_CRM_1 && op2 == `CMT_OP2_1)
					op = CMT_OP_IUNLOCK;
				if (minor_register_field == `CMT_CRM_2 && op2 == `CMT_OP2_1)
					op = CMT_OP_DUNLOCK;
			end
			`CMT_CRN_TLOCK: begin
				if (op2 == `CMT_OP2_0) begin
					if (minor_register_field == `CMT_CRM_4) op = CMT_OP_ITLB_LOCK;
					if (minor_register_field == `CMT_CRM_8) op = CMT_OP_DTLB_LOCK;
				end
				if (op2 == `CMT_OP2_1) begin
					if (minor_register_field == `CMT_CRM_4) op = CMT_OP_ITLB_UNLOCK;
					if (minor_register_field == `CMT_CRM_8) op = CMT_OP_DTLB_UNLOCK;
				end
			end
			default: op = CMT_OP_NONE;
		endcase
		cmt_decode = op;
	endfunction

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	cmt_state_type state_q;
	cmt_state_type state_d;
	cmt_op_type dec_op;
	cmt_op_type held_op_q;
	logic [31:0] held_mva_q;
	logic taken;
	logic wr_taken;
	logic rd_taken;
	logic needs_wait;
	logic wait_done;
	logic alloc_skip;
	logic wr_status;
	logic wr_addr;
	logic wr_lock;
	logic wr_pid;
	logic sel_lock;
	logic [31:0] line_mva;
	logic [31:0] rd_mux;

	assign dec_op = cmt_decode(i_cp_crn, i_cp_crm, i_cp_op2);
	assign o_cp_ready = (state_q == CMT_ST_IDLE);
	assign taken = i_cp_valid && o_cp_ready;
	assign wr_taken = taken && i_cp_write;
	assign rd_taken = taken && !i_cp_write;
	assign needs_wait = (dec_op == CMT_OP_DRAIN) ||
		(dec_op == CMT_OP_ALLOC_LINE);
	assign wait_done = (state_q == CMT_ST_WAIT) && i_mem_idle;
	assign alloc_skip = (held_op_q == CMT_OP_ALLOC_LINE) &&
		i_dc_resident;
	assign sel_lock = (i_cp_crn == `CMT_CRN_CLOCK) &&
		(i_cp_crm == `CMT_CRM_2) && (i_cp_op2 == `CMT_OP2_0);
	assign wr_status = wr_taken && (i_cp_crn == `CMT_CRN_STATUS);
	assign wr_addr = wr_taken && (i_cp_crn == `CMT_CRN_ADDR);
	assign wr_lock = wr_taken && sel_lock;
	assign wr_pid = wr_taken && (i_cp_crn == `CMT_CRN_PID) &&
		(i_cp_crm == `CMT_CRM_0) && (i_cp_op2 == `CMT_OP2_0);
	assign line_mva = {i_cp_wdata[31:`CMT_LINE_LO], 5'h00};

	always_comb begin
		state_d = state_q;
		case (state_q)
			CMT_ST_IDLE: begin
				if (wr_taken && needs_wait) state_d = CMT_ST_WAIT;
			end
			CMT_ST_WAIT: begin
				if (i_mem_idle) state_d = CMT_ST_IDLE;
			end
			default: state_d = CMT_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= CMT_ST_IDLE;
			held_op_q <= CMT_OP_NONE;
			held_mva_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			if (wr_taken && needs_wait) begin
				held_op_q <= dec_op;
				held_mva_q <= line_mva;
			end
		end
	end
	assign o_probe_mva = held_mva_q;

	// ----------------------------------------
	// Maintenance command output
	// ----------------------------------------
	// No enable or permission gating: commands run regardless.
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_maint <= '0;
		end else if (wait_done) begin
			o_maint.valid <= !alloc_skip;
			o_maint.op <= held_op_q;
			o_maint.modified_virtual_address <= held_mva_q;
		end else begin
			o_maint.valid <= wr_taken && !needs_wait &&
				(dec_op != CMT_OP_NONE);
			o_maint.op <= wr_taken ? dec_op : CMT_OP_NONE;
			o_maint.modified_virtual_address <= i_cp_wdata;
		end
	end

	// ----------------------------------------
	// Parity fault from clean line only
	// ----------------------------------------
	logic clean_pend_q;
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			clean_pend_q <= 1'b0;
			o_parity_fault <= 1'b0;
		end else begin
			if (o_maint.valid && o_maint.op == CMT_OP_CLEAN_D_LINE)
				clean_pend_q <= 1'b1;
			else if (i_clean_done)
				clean_pend_q <= 1'b0;
			o_parity_fault <= clean_pend_q && i_clean_done &&
				i_clean_parity;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [10:0] status_q;
	logic [31:0] addr_q;
	logic [6:0] pid_q;
	logic lock_q;
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_q <= `CMT_STAT_RST;
			addr_q <= `CMT_ADDR_RST;
			pid_q <= `CMT_PID_RST;
			lock_q <= `CMT_LOCK_RST;
		end else begin
			if (i_abort_take) begin
				status_q[`CMT_FS_EXT] <= i_abort_ext;
				status_q[`CMT_FS_DBG] <= i_abort_dbg;
				status_q[8] <= 1'b0;
				status_q[3:0] <= i_abort_type;
				if (i_abort_data) status_q[7:4] <= i_abort_domain;
			end else if (wr_status) begin
				status_q <= {i_cp_wdata[10:9], 1'b0, i_cp_wdata[7:0]};
			end
			if (i_abort_take && i_abort_data) addr_q <= i_abort_mva;
			else if (wr_addr) addr_q <= i_cp_wdata;
			if (wr_pid) pid_q <= i_cp_wdata[`CMT_PID_HI:`CMT_PID_LO];
			if (wr_lock) lock_q <= i_cp_wdata[0];
		end
	end
	assign o_dc_lock_mode = lock_q;

	// Command registers read as zero.
	assign rd_mux = (i_cp_crn == `CMT_CRN_STATUS) ? {21'h000000, status_q} :
		(i_cp_crn == `CMT_CRN_ADDR) ? addr_q :
		(i_cp_crn == `CMT_CRN_PID) ? {pid_q, 25'h0000000} :
		sel_lock ? {31'h00000000, lock_q} : 32'h00000000;

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_cp_rdata <= 32'h00000000;
			o_ifetch_mva <= 32'h00000000;
			o_data_mva <= 32'h00000000;
		end else begin
			if (rd_taken) o_cp_rdata <= rd_mux;
			o_ifetch_mva <= cmt_remap(i_ifetch_va, pid_q);
			o_data_mva <= cmt_remap(i_data_va, pid_q);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!rst_n_q);

	sequence s_wait_taken;
		wr_taken && needs_wait;
	endsequence
	sequence s_wait_release;
		(state_q == CMT_ST_WAIT) && i_mem_idle && !alloc_skip;
	endsequence

	chk_abort_fields: assert property (
		i_abort_take && i_abort_data |=>
		status_q[7:4] == $past(i_abort_domain) &&
		status_q[3:0] == $past(i_abort_type))
		else $error("abort status fields wrong");
	chk_abort_addr: assert property (
		i_abort_take && i_abort_data |=> addr_q == $past(i_abort_mva))
		else $error("abort address not captured");
	chk_wait_stall: assert property (
		s_wait_taken |=> !o_cp_ready && !o_maint.valid)
		else $error("wait command did not stall");
	chk_wait_issue: assert property (
		s_wait_release |=> o_maint.valid && o_maint.op == $past(held_op_q))
		else $error("held command not issued");
	chk_alloc_resident: assert property (
		wait_done && alloc_skip |=> !o_maint.valid)
		else $error("resident line allocated");
	chk_drain_idle: assert property (
		o_maint.valid && o_maint.op == CMT_OP_DRAIN |-> $past(i_mem_idle))
		else $error("drain issued while busy");
	chk_parity_clean: assert property (
		o_parity_fault |-> $past(clean_pend_q))
		else $error("parity fault without clean");
	chk_unlisted_ignored: assert property (
		wr_taken && dec_op == CMT_OP_NONE |=> !o_maint.valid)
		else $error("unlisted command acted");
	chk_iline_only: assert property (
		wr_taken && dec_op == CMT_OP_INV_I_LINE |=>
		o_maint.valid && o_maint.op == CMT_OP_INV_I_LINE)
		else $error("line invalidate altered");
	chk_remap_data: assert property (
		##1 o_data_mva == (($past(i_data_va[31:25]) == 7'h00) ?
		($past(i_data_va) | {$past(pid_q), 25'h0000000}) :
		$past(i_data_va)))
		else $error("remap mismatch");
	chk_lock_write: assert property (
		wr_lock |=> o_dc_lock_mode == $past(i_cp_wdata[0]))
		else $error("lock mode not written");
endmodule
`default_nettype wire

//--- include/cmt_consts.svh
`ifndef CMT_CONSTS_SVH
`define CMT_CONSTS_SVH
// ----------------------------------------
// Primary register numbers
// ----------------------------------------
`define CMT_CRN_STATUS 4'h5
`define CMT_CRN_ADDR 4'h6
`define CMT_CRN_CACHE 4'h7
`define CMT_CRN_TLB 4'h8
`define CMT_CRN_CLOCK 4'h9
`define CMT_CRN_TLOCK 4'hA
`define CMT_CRN_PID 4'hD
// ----------------------------------------
// Minor register and secondary opcodes
// ----------------------------------------
`define CMT_CRM_0 4'h0
`define CMT_CRM_1 4'h1
`define CMT_CRM_2 4'h2
`define CMT_CRM_4 4'h4
`define CMT_CRM_5 4'h5
`define CMT_CRM_6 4'h6
`define CMT_CRM_7 4'h7
`define CMT_CRM_8 4'h8
`define CMT_CRM_A 4'hA
`define CMT_OP2_0 3'h0
`define CMT_OP2_1 3'h1
`define CMT_OP2_4 3'h4
`define CMT_OP2_5 3'h5
`define CMT_OP2_6 3'h6
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CMT_FS_EXT 10
`define CMT_FS_DBG 9
`define CMT_PID_HI 31
`define CMT_PID_LO 25
`define CMT_LINE_LO 5
`define CMT_PID_RST 7'h00
`define CMT_LOCK_RST 1'h0
`define CMT_STAT_RST 11'h000
`define CMT_ADDR_RST 32'h00000000
`endif

//--- include/cmt_pkg.sv
package cmt_pkg;
	typedef enum logic [4:0] {
		CMT_OP_NONE, CMT_OP_INV_ID_BTB, CMT_OP_INV_I_BTB, CMT_OP_INV_I_LINE,
		CMT_OP_INV_D, CMT_OP_INV_D_LINE, CMT_OP_CLEAN_D_LINE, CMT_OP_DRAIN,
		CMT_OP_INV_BTB, CMT_OP_ALLOC_LINE, CMT_OP_TLB_INV_ALL,
		CMT_OP_TLB_INV_I, CMT_OP_TLB_INV_D, CMT_OP_TLB_INV_I_ENT,
		CMT_OP_TLB_INV_D_ENT, CMT_OP_ILOCK_LINE, CMT_OP_IUNLOCK,
		CMT_OP_DUNLOCK, CMT_OP_ITLB_LOCK, CMT_OP_DTLB_LOCK,
		CMT_OP_ITLB_UNLOCK, CMT_OP_DTLB_UNLOCK
	} cmt_op_type;
	typedef enum logic [0:0] {CMT_ST_IDLE, CMT_ST_WAIT} cmt_state_type;
	typedef struct packed {
		logic valid;
		cmt_op_type op;
		logic [31:0] modified_virtual_address;
	} cmt_maint_type;
endpackage

//--- verif/cmt_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Memory side responder
// ----------------------------------------
module cmt_mem_model
	import cmt_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire cmt_maint_type i_maint,
	output logic o_mem_idle,
	output logic o_clean_done,
	output logic o_clean_parity
);
	logic [7:0] lf_q;
	logic [1:0] cnt_q;
	wire logic start_clean;
	assign start_clean = i_maint.valid && (i_maint.op == CMT_OP_CLEAN_D_LINE);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lf_q <= 8'h5A;
			cnt_q <= 2'h0;
		end else begin
			lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
			if (start_clean) begin
				cnt_q <= 2'h2;
			end else if (cnt_q != 2'h0) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end
	// Buffers busy about a quarter of the cycles
	assign o_mem_idle = lf_q[1] | lf_q[0];
	// Clean answers two cycles later, parity random
	assign o_clean_done = (cnt_q == 2'h1);
	assign o_clean_parity = lf_q[2];
endmodule
`default_nettype wire

//--- verif/cache_tlb_maintenance_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cache_tlb_maintenance_control_tb_top
	import cmt_pkg::*;
;
	logic clk, rst_n, cp_valid, cp_write, dc_res, run, pf_exp, exp_lock;
	logic abort_take, abort_data, abort_ext, abort_dbg, pv, ev;
	logic [3:0] cp_crn, cp_crm, dom, atype, pdom;
	logic [2:0] cp_op2;
	logic [31:0] cp_wdata, abort_mva, if_va, d_va, seed, d, r, v, rd;
	logic [31:0] pm, paddr, pe;
	wire logic cp_ready, pfault, lock_mode, mem_idle, cdone, cpar;
	wire logic [31:0] rdata, if_mva, d_mva, probe;
	wire cmt_maint_type maint;
	cmt_op_type eo, pop;
	int num_errors, checked, cyc, n, m, o, i;
	cmt_ctrl dut (.i_clk(clk), .i_reset_n(rst_n), .i_cp_valid(cp_valid),
		.i_cp_write(cp_write), .i_cp_crn(cp_crn), .i_cp_crm(cp_crm),
		.i_cp_op2(cp_op2), .i_cp_wdata(cp_wdata), .o_cp_ready(cp_ready),
		.o_cp_rdata(rdata), .i_abort_take(abort_take),
		.i_abort_data(abort_data), .i_abort_ext(abort_ext),
		.i_abort_dbg(abort_dbg), .i_abort_domain(dom), .i_abort_type(atype),
		.i_abort_mva(abort_mva), .i_ifetch_va(if_va), .i_data_va(d_va),
		.o_ifetch_mva(if_mva), .o_data_mva(d_mva), .i_mem_idle(mem_idle),
		.i_dc_resident(dc_res), .o_probe_mva(probe), .o_maint(maint),
		.i_clean_done(cdone), .i_clean_parity(cpar),
		.o_parity_fault(pfault), .o_dc_lock_mode(lock_mode));
	cmt_mem_model mem (.i_clk(clk), .i_reset_n(rst_n), .i_maint(maint),
		.o_mem_idle(mem_idle), .o_clean_done(cdone), .o_clean_parity(cpar));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] remap(input logic [31:0] a,
		input logic [6:0] p);
		return (a[31:25] == 7'h00) ? {p, a[24:0]} : a;
	endfunction
	function automatic cmt_op_type exp_op(input logic [3:0] cn,
		input logic [3:0] cm, input logic [2:0] co);
		case ({cn, cm, co})
			{4'h7, 4'h7, 3'h0}: return CMT_OP_INV_ID_BTB;
			{4'h7, 4'h5, 3'h0}: return CMT_OP_INV_I_BTB;
			{4'h7, 4'h5, 3'h1}: return CMT_OP_INV_I_LINE;
			{4'h7, 4'h6, 3'h0}: return CMT_OP_INV_D;
			{4'h7, 4'h6, 3'h1}: return CMT_OP_INV_D_LINE;
			{4'h7, 4'hA, 3'h1}: return CMT_OP_CLEAN_D_LINE;
			{4'h7, 4'hA, 3'h4}: return CMT_OP_DRAIN;
			{4'h7, 4'h5, 3'h6}: return CMT_OP_INV_BTB;
			{4'h7, 4'h2, 3'h5}: return CMT_OP_ALLOC_LINE;
			{4'h8, 4'h7, 3'h0}: return CMT_OP_TLB_INV_ALL;
			{4'h8, 4'h5, 3'h0}: return CMT_OP_TLB_INV_I;
			{4'h8, 4'h6, 3'h0}: return CMT_OP_TLB_INV_D;
			{4'h8, 4'h5, 3'h1}: return CMT_OP_TLB_INV_I_ENT;
			{4'h8, 4'h6, 3'h1}: return CMT_OP_TLB_INV_D_ENT;
			{4'h9, 4'h1, 3'h0}: return CMT_OP_ILOCK_LINE;
			{4'h9, 4'h1, 3'h1}: return CMT_OP_IUNLOCK;
			{4'h9, 4'h2, 3'h1}: return CMT_OP_DUNLOCK;
			{4'hA, 4'h4, 3'h0}: return CMT_OP_ITLB_LOCK;
			{4'hA, 4'h8, 3'h0}: return CMT_OP_DTLB_LOCK;
			{4'hA, 4'h4, 3'h1}: return CMT_OP_ITLB_UNLOCK;
			{4'hA, 4'h8, 3'h1}: return CMT_OP_DTLB_UNLOCK;
			default: return CMT_OP_NONE;
		endcase
	endfunction
	task cmp_val(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task cmp_bit(input logic g, input logic e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task cmp_op(input cmt_op_type g, input cmt_op_type e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One access, then collect any command pulse
	task access(input logic w, input logic [3:0] cn, input logic [3:0] cm,
		input logic [2:0] co, input logic [31:0] dd);
		int k;
		@(posedge clk);
		cp_valid <= 1'b1;
		cp_write <= w;
		cp_crn <= cn;
		cp_crm <= cm;
		cp_op2 <= co;
		cp_wdata <= dd;
		#1;
		while (cp_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		cp_valid <= 1'b0;
		cp_wdata <= ~dd;
		pv = 1'b0;
		pop = CMT_OP_NONE;
		pm = 32'h00000000;
		for (k = 0; k < 40; k++) begin
			#1;
			if (maint.valid === 1'b1) begin
				pv = 1'b1;
				pop = maint.op;
				pm = maint.modified_virtual_address;
			end
			if (k > 0 && cp_ready === 1'b1) break;
			@(posedge clk);
		end
		rd = rdata;
	endtask
	task report_and_stop();
		$display("errors=%0d checked=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog, parity monitor
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	always @(posedge clk) begin
		pf_exp = cdone & cpar;
		#1;
		if (run) cmp_bit(pfault, pf_exp);
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{cp_valid, cp_write, dc_res, abort_take, abort_data} = 5'h00;
		{abort_ext, abort_dbg, run, exp_lock} = 4'h0;
		{cp_crn, cp_crm, cp_op2, dom, atype} = 19'h00000;
		{cp_wdata, abort_mva, if_va, d_va} = 128'h0;
		rst_n = 1'b0;
		seed = 32'h0000DA18;
		num_errors = 0;
		checked = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		run = 1'b1;
		for (n = 7; n < 13; n++)
		for (m = 0; m < 16; m++)
		for (o = 0; o < 8; o++) begin
			d = rnd();
			r = rnd();
			@(posedge clk);
			dc_res <= r[0];
			eo = exp_op(n[3:0], m[3:0], o[2:0]);
			ev = (eo != CMT_OP_NONE) && !(eo == CMT_OP_ALLOC_LINE && r[0]);
			access(1'b1, n[3:0], m[3:0], o[2:0], d);
			if (n == 9 && m == 2 && o == 0) exp_lock = d[0];
			cmp_bit(pv, ev);
			if (ev) begin
				cmp_op(pop, eo);
				pe = d;
				if (eo == CMT_OP_ALLOC_LINE || eo == CMT_OP_DRAIN)
					pe[4:0] = 5'h00;
				cmp_val(pm, pe);
			end
			if (eo == CMT_OP_ALLOC_LINE)
				cmp_val(probe, {d[31:5], 5'h00});
			cmp_bit(lock_mode, exp_lock);
		end
		access(1'b0, 4'h9, 4'h2, 3'h0, 32'h00000000);
		cmp_val(rd, {31'h00000000, exp_lock});
		access(1'b0, 4'hB, 4'h0, 3'h0, 32'h00000000);
		cmp_val(rd, 32'h00000000);
		$display("test commands done");
		pdom = 4'h0;
		paddr = 32'h00000000;
		for (i = 0; i < 8; i++) begin
			r = rnd();
			d = rnd();
			r[0] = r[0] | (i == 0);
			@(posedge clk);
			abort_take <= 1'b1;
			abort_data <= r[0];
			{abort_dbg, abort_ext} <= r[2:1];
			dom <= r[7:4];
			atype <= r[11:8];
			abort_mva <= d;
			@(posedge clk);
			abort_take <= 1'b0;
			if (r[0]) begin
				pdom = r[7:4];
				paddr = d;
			end
			access(1'b0, 4'h5, 4'h0, 3'h0, 32'h00000000);
			cmp_val(rd, {21'h0, r[1], r[2], 1'b0, pdom, r[11:8]});
			access(1'b0, 4'h6, 4'h0, 3'h0, 32'h00000000);
			cmp_val(rd, paddr);
		end
		$display("test aborts done");
		for (i = 0; i < 16; i++) begin
			r = rnd();
			d = rnd();
			v = rnd();
			if (i[0]) d[31:25] = 7'h00;
			else v[31:25] = 7'h00;
			access(1'b1, 4'hD, 4'h0, 3'h0, {r[31:25], 25'h0});
			access(1'b0, 4'hD, 4'h0, 3'h0, 32'h00000000);
			cmp_val(rd, {r[31:25], 25'h0});
			@(posedge clk);
			if_va <= v;
			d_va <= d;
			@(posedge clk);
			#1;
			cmp_val(d_mva, remap(d, r[31:25]));
			cmp_val(if_mva, remap(v, r[31:25]));
		end
		$display("test remap done");
		report_and_stop();
	end
endmodule
`default_nettype wire
